// file: common/ctr_regs.vh
/*
 * Register offsets, field positions, reset values and prescaler taps for the
 * capture timer run/mode control block.
 * Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
 */
`ifndef CTR_REGS_VH
`define CTR_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CTR_OFS_ENABLE   8'h00
`define CTR_OFS_RUN      8'h04
`define CTR_OFS_CTRL     8'h08
`define CTR_OFS_MODE     8'h0c
`define CTR_OFS_CAP_A    8'h10
`define CTR_OFS_CAP_B    8'h14
`define CTR_OFS_CMP_B    8'h18
`define CTR_OFS_COUNT    8'h1c
`define CTR_OFS_STATUS   8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTR_EN_BIT       7
`define CTR_RUN_CNT_BIT  0
`define CTR_RUN_PRE_BIT  2
`define CTR_CR_DBUF_BIT  7
`define CTR_CR_SYNC_BIT  5
`define CTR_CR_IDLE_BIT  3
`define CTR_MOD_SWCP_BIT 5
`define CTR_MOD_CLE_BIT  2

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define CTR_CPM_OFF      2'h0
`define CTR_CPM_PINS     2'h1
`define CTR_CPM_PINA     2'h2
`define CTR_CPM_PAIR     2'h3
`define CTR_CLK_PIN      2'h0
`define CTR_CLK_DIV1     2'h1
`define CTR_CLK_DIV4     2'h2
`define CTR_CLK_DIV16    2'h3
`define CTR_CR_RESET     8'h00
`define CTR_MOD_RESET    7'h00
`define CTR_CMP_RESET    16'h0000

// ----------------------------------------
// Prescaler tap positions
// ----------------------------------------
`define CTR_PRE_W        4
`define CTR_TAP4_BIT     1
`define CTR_TAP16_BIT    3

`endif

// file: logic/ctr_timer.v
/*
 * One 16-bit capture timer channel: run control, mode control,
 * prescaler, counter, capture and match-clear, with an AXI4-Lite slave.
 * Assumes capture pins and the paired match output are asynchronous,
 * and that idle_mode and sync_start come from logic on clk.
 */
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
// Notes on behaviour
// RL1: Prescaler run bit counts, else stops, clears
// RL2: Counter run bit counts, else stops, clears
// RL3: Double buffer bit selects buffered compare write
// RL4: Sync bit waits for master start
// RL5: Idle bit keeps counting during idle
// RL6: Software changes control only while stopped; control writes are also taken while running
// RL7: Writing zero soft capture loads capture A
// RL8: Capture timing 00 disables hardware capture
// RL9: Mode 01: pin A rise, pin B rise
// RL10: Mode 10: pin A rise and fall
// RL11: Mode 11: paired match output edges capture
// RL12: Match clear zeroes counter on compare B
// RL13: Source select: pin, div1, div4, div16
// RL14: Counter, one compare (B), two captures present
// RL15: Disabled channel freezes registers, blocks access
// RL16: Reserved bits read zero, ignore writes
// RL17: Pin edges synchronised into one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "ctr_regs.vh"

module ctr_timer (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire idle_mode,
    input wire sync_start,
    input wire capture_pin_a,
    input wire capture_pin_b,
    input wire paired_match_output,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg match_b_reg
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg enable_reg;                // Channel enable
reg prescaler_run_reg;         // Prescaler run
reg counter_run_reg;           // Counter run
reg double_buffer_enable_reg;  // Compare double buffer
reg ctrl6_reg;                 // Keep-zero read-write bit
reg sync_start_select_reg;     // Start with master
reg idle_operate_reg;          // Run during idle
reg [1:0] ctrl_lo_reg;         // Keep-zero read-write bits
reg mode6_reg;                 // Keep-zero read-write bit
reg [1:0] capture_timing_reg;  // Hardware capture mode
reg match_clear_enable_reg;    // Clear on compare B match
reg [1:0] source_clock_select_reg; // Count source
reg [15:0] compare_reg_b_reg;  // Active compare value
reg [15:0] compare_buf_reg;    // Buffered compare value
reg [15:0] capture_reg_a_reg;  // Capture register A
reg [15:0] capture_reg_b_reg;  // Capture register B
reg [15:0] count_reg;          // Up-counter
reg [`CTR_PRE_W-1:0] pre_reg;  // Prescaler
reg [`CTR_PRE_W-1:0] pre_prev_reg; // Last prescaler, for tap edges
reg [2:0] sync1_reg;           // First synchroniser stage
reg [2:0] sync2_reg;           // Second synchroniser stage
reg [2:0] sync3_reg;           // Delayed copy for edge detect
reg [7:0] wr_addr_reg;         // Latched write address
reg wr_addr_ok_reg;            // Write address held
reg [31:0] wr_data_reg;        // Latched write data
reg [3:0] wr_strb_reg;         // Latched strobes
reg wr_data_ok_reg;            // Write data held
reg soft_cap_reg;              // Soft capture request
wire [2:0] rise;               // Rising edge pulses
wire [2:0] fall;               // Falling edge pulses
wire gate;                     // Channel clocked at all
wire running;                  // Counter may advance
wire tick;                     // Count source pulse
wire cap_a;                    // Load capture A
wire cap_b;                    // Load capture B
wire do_write;                 // Write performed this cycle
wire at_match;                 // Counter equals compare B

// ----------------------------------------
// Input synchronisers and edge pulses
// ----------------------------------------
// Two-flop sync, third flop for edges; edges only from stage two on
always @(posedge clk)
begin
    if (!rst_n)
    begin
        sync1_reg <= 3'h0;
        sync2_reg <= 3'h0;
        sync3_reg <= 3'h0;
    end
    else if (clk_en)
    begin
        sync1_reg <= {paired_match_output, capture_pin_b, capture_pin_a};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg; // RL17
    end
end

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_edge
        assign rise[gi] = sync2_reg[gi] & ~sync3_reg[gi]; // RL17
        assign fall[gi] = ~sync2_reg[gi] & sync3_reg[gi];
    end
endgenerate

// ----------------------------------------
// Run qualification
// ----------------------------------------
// Enable gates counting state and register access; idle and sync start further qualify
assign gate = enable_reg; // RL15
assign running = counter_run_reg & (~idle_mode | idle_operate_reg) // RL5
    & (~sync_start_select_reg | sync_start); // RL4

// Source pulse: pin rise, prescaler run bit (div1), or prescaler tap rising edge
assign tick = (source_clock_select_reg == `CTR_CLK_PIN) ? rise[0] : // RL13
    (source_clock_select_reg == `CTR_CLK_DIV1) ? prescaler_run_reg :
    (source_clock_select_reg == `CTR_CLK_DIV4) ?
        (pre_reg[`CTR_TAP4_BIT] & ~pre_prev_reg[`CTR_TAP4_BIT]) :
        (pre_reg[`CTR_TAP16_BIT] & ~pre_prev_reg[`CTR_TAP16_BIT]);

assign at_match = (count_reg == compare_reg_b_reg);

// Capture sources by timing mode; 00 gives soft capture only
assign cap_a = soft_cap_reg | // RL7
    (((capture_timing_reg == `CTR_CPM_PINS) | (capture_timing_reg == `CTR_CPM_PINA))
        & rise[0]) | // RL9 RL10
    ((capture_timing_reg == `CTR_CPM_PAIR) & rise[2]); // RL11 RL8
assign cap_b = ((capture_timing_reg == `CTR_CPM_PINS) & rise[1]) | // RL9
    ((capture_timing_reg == `CTR_CPM_PINA) & fall[0]) | // RL10
    ((capture_timing_reg == `CTR_CPM_PAIR) & fall[2]); // RL11

// ----------------------------------------
// Prescaler, counter, captures
// ----------------------------------------
// Counting state; frozen while disabled or clock enable low
always @(posedge clk)
begin
    if (!rst_n)
    begin
        pre_reg <= {`CTR_PRE_W{1'b0}};
        pre_prev_reg <= {`CTR_PRE_W{1'b0}};
        count_reg <= 16'h0000;
        capture_reg_a_reg <= 16'h0000;
        capture_reg_b_reg <= 16'h0000;
        match_b_reg <= 1'b0;
    end
    else if (clk_en && gate)
    begin
        // Prescaler runs or stops and clears
        if (prescaler_run_reg)
            pre_reg <= pre_reg + {{(`CTR_PRE_W-1){1'b0}}, 1'b1}; // RL1
        else
            pre_reg <= {`CTR_PRE_W{1'b0}}; // RL1
        pre_prev_reg <= pre_reg;
        // Counter runs, clears on match, or stops and clears
        if (!counter_run_reg)
            count_reg <= 16'h0000; // RL2
        else if (running && tick)
        begin
            if (match_clear_enable_reg && at_match)
                count_reg <= 16'h0000; // RL12
            else
                count_reg <= count_reg + 16'h0001; // RL2 RL14
        end
        match_b_reg <= counter_run_reg & at_match;
        if (cap_a)
            capture_reg_a_reg <= count_reg; // RL7 RL14
        if (cap_b)
            capture_reg_b_reg <= count_reg; // RL14
    end
end

// ----------------------------------------
// AXI4-Lite write path
// ----------------------------------------
assign do_write = wr_addr_ok_reg & wr_data_ok_reg & ~s_axi_bvalid;

// Take address and data in either order, answer after both
always @(posedge clk)
begin
    if (!rst_n)
    begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        wr_addr_reg <= 8'h00;
        wr_addr_ok_reg <= 1'b0;
        wr_data_reg <= 32'h00000000;
        wr_strb_reg <= 4'h0;
        wr_data_ok_reg <= 1'b0;
        enable_reg <= 1'b0;
        prescaler_run_reg <= 1'b0;
        counter_run_reg <= 1'b0;
        double_buffer_enable_reg <= 1'b0;
        ctrl6_reg <= 1'b0;
        sync_start_select_reg <= 1'b0;
        idle_operate_reg <= 1'b0;
        ctrl_lo_reg <= 2'h0;
        mode6_reg <= 1'b0;
        capture_timing_reg <= 2'h0;
        match_clear_enable_reg <= 1'b0;
        source_clock_select_reg <= 2'h0;
        compare_reg_b_reg <= `CTR_CMP_RESET;
        compare_buf_reg <= `CTR_CMP_RESET;
        soft_cap_reg <= 1'b0;
    end
    else if (clk_en)
    begin
        s_axi_awready <= ~wr_addr_ok_reg & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready <= ~wr_data_ok_reg & ~s_axi_wready & s_axi_wvalid;
        soft_cap_reg <= 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            wr_addr_reg <= s_axi_awaddr;
            wr_addr_ok_reg <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
            wr_data_ok_reg <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        // Double buffer: load active compare at match when enabled
        if (gate && double_buffer_enable_reg && at_match)
            compare_reg_b_reg <= compare_buf_reg; // RL3
        if (do_write)
        begin
            wr_addr_ok_reg <= 1'b0;
            wr_data_ok_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            if (wr_addr_reg == `CTR_OFS_ENABLE)
            begin
                if (wr_strb_reg[0])
                    enable_reg <= wr_data_reg[`CTR_EN_BIT];
            end
            else if (!gate)
                s_axi_bresp <= 2'h2; // RL15
            else if (wr_strb_reg[0])
            begin
                // Only documented bits stored; reserved read-zero ignored
                case (wr_addr_reg)
                    `CTR_OFS_RUN:
                    begin
                        prescaler_run_reg <= wr_data_reg[`CTR_RUN_PRE_BIT]; // RL1
                        counter_run_reg <= wr_data_reg[`CTR_RUN_CNT_BIT]; // RL2
                    end
                    `CTR_OFS_CTRL:
                    begin
                        double_buffer_enable_reg <= wr_data_reg[`CTR_CR_DBUF_BIT]; // RL3
                        ctrl6_reg <= wr_data_reg[6];
                        sync_start_select_reg <= wr_data_reg[`CTR_CR_SYNC_BIT]; // RL4
                        idle_operate_reg <= wr_data_reg[`CTR_CR_IDLE_BIT]; // RL5
                        ctrl_lo_reg <= wr_data_reg[1:0]; // RL16
                    end
                    `CTR_OFS_MODE:
                    begin
                        mode6_reg <= wr_data_reg[6]; // RL16
                        soft_cap_reg <= ~wr_data_reg[`CTR_MOD_SWCP_BIT]; // RL7
                        capture_timing_reg <= wr_data_reg[4:3]; // RL8
                        match_clear_enable_reg <= wr_data_reg[`CTR_MOD_CLE_BIT]; // RL12
                        source_clock_select_reg <= wr_data_reg[1:0]; // RL13
                    end
                    `CTR_OFS_CMP_B:
                    begin
                        compare_buf_reg <= {wr_strb_reg[1] ? wr_data_reg[15:8] :
                            compare_buf_reg[15:8], wr_data_reg[7:0]};
                        if (!double_buffer_enable_reg)
                            compare_reg_b_reg <= {wr_strb_reg[1] ? wr_data_reg[15:8] :
                                compare_reg_b_reg[15:8], wr_data_reg[7:0]}; // RL3
                    end
                    default:
                        s_axi_bresp <= 2'h0;
                endcase
            end
        end
    end
end

// ----------------------------------------
// AXI4-Lite read path
// ----------------------------------------
// One read at a time; data answered the cycle after address taken
always @(posedge clk)
begin
    if (!rst_n)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h0;
    end
    else if (clk_en)
    begin
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000; // RL16
            if (s_axi_araddr == `CTR_OFS_ENABLE)
                s_axi_rdata[`CTR_EN_BIT] <= enable_reg;
            else if (!gate)
                s_axi_rresp <= 2'h2; // RL15
            else
            begin
                case (s_axi_araddr)
                    `CTR_OFS_RUN:
                        s_axi_rdata[2:0] <= {prescaler_run_reg, 1'b0, counter_run_reg};
                    `CTR_OFS_CTRL:
                        s_axi_rdata[7:0] <= {double_buffer_enable_reg, ctrl6_reg,
                            sync_start_select_reg, 1'b0, idle_operate_reg, 1'b0,
                            ctrl_lo_reg};
                    `CTR_OFS_MODE:
                        s_axi_rdata[6:0] <= {mode6_reg, 1'b1, capture_timing_reg,
                            match_clear_enable_reg, source_clock_select_reg}; // RL7
                    `CTR_OFS_CAP_A:
                        s_axi_rdata[15:0] <= capture_reg_a_reg;
                    `CTR_OFS_CAP_B:
                        s_axi_rdata[15:0] <= capture_reg_b_reg;
                    `CTR_OFS_CMP_B:
                        s_axi_rdata[15:0] <= compare_reg_b_reg;
                    `CTR_OFS_COUNT:
                        s_axi_rdata[15:0] <= count_reg;
                    `CTR_OFS_STATUS:
                        s_axi_rdata[1:0] <= {match_b_reg, running};
                    default:
                        s_axi_rresp <= 2'h0;
                endcase
            end
        end
    end
end

endmodule // ctr_timer
`default_nettype wire

// file: verif/ctr_pin_model.sv
/* Stand-in for the capture pins and the paired channel's match output.
   Assumes the bench requests pin levels in step with clk. */
`timescale 1ns/10ps
`default_nettype none
module ctr_pin_model (
    input wire logic clk,
    input wire logic [2:0] req,
    output logic pin_a,
    output logic pin_b,
    output logic pin_m
);
    // Pins change just after an edge, as an unrelated driver would
    always @(posedge clk)
    begin
        pin_a <= req[0];
        pin_b <= req[1];
        pin_m <= req[2];
    end
endmodule // ctr_pin_model
`default_nettype wire

// file: verif/ctr_timer_monitor.sv
/* Checker for the capture timer register bus: field and refusal rules.
   Assumes clk_en is held high and bready/rready are always high. */
`timescale 1ns/10ps
`default_nettype none
module ctr_timer_chk (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid
);
    logic [7:0] aw_q; // Last write address taken
    logic [7:0] ar_q; // Last read address taken
    logic w_q; // Enable bit of last write data
    logic en_q; // Shadow of the channel enable
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Shadow of addresses and enable
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_q <= 8'h00;
            ar_q <= 8'h00;
            w_q <= 1'b0;
            en_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                w_q <= s_axi_wdata[7];
            if (s_axi_arvalid && s_axi_arready)
                ar_q <= s_axi_araddr;
            if ($rose(s_axi_bvalid) && aw_q == 8'h00)
                en_q <= w_q;
        end
    end
    chk_off_read_err: assert property (s_axi_rvalid && !en_q && ar_q != 8'h00
        && ar_q <= 8'h20 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("disabled read not refused");
    chk_off_write_err: assert property (s_axi_bvalid && !en_q && aw_q != 8'h00
        && aw_q <= 8'h20 |-> s_axi_bresp == 2'h2) else $error("disabled write not refused");
    chk_enable_bits_zero: assert property (s_axi_rvalid && ar_q == 8'h00
        |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:0] == 7'h0) else $error("enable bits");
    chk_run_bits_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 && ar_q == 8'h04
        |-> s_axi_rdata[31:3] == 29'h0 && !s_axi_rdata[1]) else $error("run reserved bits");
    chk_ctrl_bits_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 && ar_q == 8'h08
        |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4] == 1'b0 && s_axi_rdata[2] == 1'b0)
        else $error("control reserved bits");
    chk_soft_cap_one: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 && ar_q == 8'h0c
        |-> s_axi_rdata[5] && s_axi_rdata[31:7] == 25'h0) else $error("mode read value");
    chk_wide_sixteen: assert property (s_axi_rvalid && ar_q >= 8'h10 && ar_q <= 8'h1c
        |-> s_axi_rdata[31:16] == 16'h0) else $error("counter width");
    chk_unmapped_okay: assert property (s_axi_rvalid && en_q && ar_q > 8'h20
        |-> s_axi_rresp == 2'h0 && s_axi_rdata == 32'h0) else $error("unmapped read");
    cov_read_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cov_enable_write: cover property ($rose(s_axi_bvalid) && aw_q == 8'h00);
    cov_capture_read: cover property (s_axi_rvalid && ar_q == 8'h14 && s_axi_rdata != 32'h0);
endmodule // ctr_timer_chk
bind ctr_timer ctr_timer_chk u_chk (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

// file: verif/testbench.sv
/* Self-checking bench for the capture timer over its AXI4-Lite slave.
   Assumes the pin model and the bound checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, rst_n, clk_en, idle_mode, sync_start;
    logic [2:0] req;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire pin_a, pin_b, pin_m, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, match_b_reg;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer fails, n_checks;
    ctr_timer DUT (.clk, .rst_n, .clk_en, .idle_mode, .sync_start, .capture_pin_a(pin_a),
        .capture_pin_b(pin_b), .paired_match_output(pin_m), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_b_reg);
    ctr_pin_model u_pins (.clk, .req, .pin_a, .pin_b, .pin_m);
    // ----------------------------------------
    // Clock, verdict and bus tasks
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task timeout;
        begin
            $display("CHECK FAILED at %0t: bus answer exp 0x1 got 0x0", $time);
            fails = fails + 1;
            print_verdict;
        end
    endtask
    // Write one word; both channels offered together
    task wr(input [7:0] a, input [31:0] d);
        integer i;
        logic done;
        begin
            done = 1'b0;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            for (i = 0; i < 40 && !done; i = i + 1)
            begin
                @(posedge clk);
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
                done = (s_axi_bvalid === 1'b1);
            end
            if (!done)
                timeout;
        end
    endtask
    // Read one word and compare data and response
    task rd(input [7:0] a, input [31:0] d, input [1:0] r);
        integer i;
        logic done;
        begin
            done = 1'b0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            for (i = 0; i < 40 && !done; i = i + 1)
            begin
                @(posedge clk);
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
                done = (s_axi_rvalid === 1'b1);
            end
            if (!done)
                timeout;
            else
            begin
                n_checks = n_checks + 1;
                if ({s_axi_rresp, s_axi_rdata} !== {r, d})
                begin
                    $display("CHECK FAILED at %0t: addr 0x%h exp 0x%h got 0x%h", $time, a,
                        {r, d}, {s_axi_rresp, s_axi_rdata});
                    fails = fails + 1;
                end
            end
        end
    endtask
    // Count edges until the registered match output is seen high
    task wait_match(input integer n);
        integer i;
        begin
            i = 0;
            while (match_b_reg !== 1'b1 && i < 60)
            begin
                @(posedge clk);
                i = i + 1;
            end
            if (match_b_reg !== 1'b1)
                timeout;
            else
            begin
                n_checks = n_checks + 1;
                if (i != n)
                begin
                    $display("CHECK FAILED at %0t: match edges exp 0x%h got 0x%h", $time, n, i);
                    fails = fails + 1;
                end
            end
        end
    endtask
    // One high pulse on a pin; sync delay is three edges
    task pulse(input integer w);
        begin
            req[w] <= 1'b1;
            repeat (4) @(posedge clk);
            req[w] <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        fails = 0;
        n_checks = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        idle_mode = 1'b0;
        sync_start = 1'b0;
        req = 3'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h04, 32'h0, 2'h2);
        wr(8'h00, 32'h80);
        rd(8'h00, 32'h80, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h0c, 32'h20, 2'h0);
        rd(8'h40, 32'h0, 2'h0);
        wr(8'h04, 32'hffffffff);
        rd(8'h04, 32'h5, 2'h0);
        wr(8'h04, 32'h0);
        $display("test access done");
        wr(8'h0c, 32'h20);
        wr(8'h04, 32'h5);
        repeat (3) pulse(0);
        rd(8'h1c, 32'h3, 2'h0);
        wr(8'h0c, 32'h28);
        pulse(1);
        rd(8'h14, 32'h3, 2'h0);
        wr(8'h0c, 32'h20);
        pulse(0);
        pulse(1);
        rd(8'h14, 32'h3, 2'h0);
        wr(8'h0c, 32'h00);
        rd(8'h10, 32'h4, 2'h0);
        wr(8'h0c, 32'h30);
        pulse(0);
        rd(8'h14, 32'h5, 2'h0);
        wr(8'h0c, 32'h20);
        pulse(0);
        wr(8'h0c, 32'h38);
        pulse(2);
        rd(8'h10, 32'h6, 2'h0);
        rd(8'h14, 32'h6, 2'h0);
        wr(8'h04, 32'h4);
        rd(8'h1c, 32'h0, 2'h0);
        $display("test capture done");
        wr(8'h18, 32'h3);
        wr(8'h0c, 32'h24);
        wr(8'h04, 32'h5);
        repeat (3) pulse(0);
        rd(8'h20, 32'h3, 2'h0);
        pulse(0);
        rd(8'h1c, 32'h0, 2'h0);
        rd(8'h18, 32'h3, 2'h0);
        $display("test match clear done");
        wr(8'h04, 32'h0);
        idle_mode <= 1'b1;
        wr(8'h04, 32'h5);
        pulse(0);
        rd(8'h1c, 32'h0, 2'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h8);
        wr(8'h04, 32'h5);
        pulse(0);
        rd(8'h1c, 32'h1, 2'h0);
        idle_mode <= 1'b0;
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h20);
        wr(8'h04, 32'h5);
        pulse(0);
        rd(8'h1c, 32'h0, 2'h0);
        sync_start <= 1'b1;
        pulse(0);
        rd(8'h1c, 32'h1, 2'h0);
        wr(8'h04, 32'h0);
        $display("test idle and sync done");
        wr(8'h00, 32'h0);
        rd(8'h08, 32'h0, 2'h2);
        wr(8'h08, 32'h8);
        rd(8'h00, 32'h0, 2'h0);
        wr(8'h00, 32'h80);
        rd(8'h08, 32'h20, 2'h0);
        $display("test disable done");
        wr(8'h08, 32'h0);
        wr(8'h18, 32'h2);
        wr(8'h0c, 32'h22);
        wr(8'h04, 32'h5);
        wait_match(8);
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h23);
        wr(8'h04, 32'h5);
        wait_match(26);
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h21);
        wr(8'h04, 32'h5);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
        wait_match(3);
        wr(8'h04, 32'h0);
        $display("test source clock done");
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
